// ===== serial_command_port.sv
// two-wire and four-wire slave command port of a display driver
// assumes the command decoder answers read requests on the same clock
// assumes host pins are asynchronous and pass the synchronisers here
`timescale 1ns/10ps
module serial_command_port (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic interface_select_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_select_low_i,
  input wire logic address_strap_bit1_i,
  output logic serial_data_out_pin_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output serial_command_port_pkg::rx_word_s rx_word_o,
  output logic rd_req_o,
  output serial_command_port_pkg::rd_req_s rd_info_o,
  input wire logic [7:0] rd_data_i
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // two-stage synchronisers, one per host pin
    logic [1:0] s_scl;
    logic [1:0] s_sda;
    logic [1:0] s_ss;
    logic [1:0] s_sel;
    logic [1:0] s_a1;
    // third stage: previous synchronised level, for edge detection on scl and sda; ss and sel are read as levels
    logic scl;
    logic sda;
    logic ss;
    logic sel;
    // two-wire sequencer
    serial_command_port_pkg::tw_state_e tw;
    // bit count within the current byte
    logic [2:0] cnt;
    // receive shifter, msb enters first
    logic [7:0] sh;
    // transmit shifter, msb leaves first
    logic [7:0] tx;
    // next completed byte is the command byte
    logic first;
    // direction of the current frame, set means read
    logic rd_dir;
    // command address of the current four-wire frame
    logic [6:0] cmd;
    // index of the next parameter asked of the decoder
    logic [7:0] idx;
    // open-drain pull-down of the two-wire data line
    logic sda_oe;
    // four-wire read data pin level
    logic so;
    // one-cycle read request toward the decoder
    logic req;
    // two-entry receive buffer and its pointers
    serial_command_port_pkg::rx_word_s [1:0] fifo;
    logic [1:0] fcnt;
    logic wp;
    logic rp;
  } state_s;

  state_s q, d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  // msb leaves first, zero fills from below
  function automatic logic [7:0] shift_out(input logic [7:0] v);
    shift_out = {v[6:0], 1'b0};
  endfunction : shift_out

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  // edges of the synchronised host clock, three cycles late
  logic scl_rise, scl_fall;
  // two-wire framing: data moving while clock stands high
  logic start_c, stop_c;
  // one word offered to the receive buffer this cycle
  logic push;
  serial_command_port_pkg::rx_word_s push_w;
  // buffer state seen this cycle
  logic full;
  logic pop;

  always_comb begin
    d = q;
    push = 1'b0;
    push_w = '0;
    full = (q.fcnt == 2'(serial_command_port_pkg::buf_depth));
    pop = (q.fcnt != 2'h0) && rx_ready_i;
    // ----------------------------------------------------------------
    // synchronisers: first stage read only by second
    // ----------------------------------------------------------------
    d.s_scl = {q.s_scl[0], scl_i};
    d.s_sda = {q.s_sda[0], sda_i};
    d.s_ss = {q.s_ss[0], slave_select_low_i};
    d.s_sel = {q.s_sel[0], interface_select_pin_i};
    // strap is static in use but still synchronised, it is a pin
    d.s_a1 = {q.s_a1[0], address_strap_bit1_i};
    d.scl = q.s_scl[1];
    d.sda = q.s_sda[1];
    d.ss = q.s_ss[1];
    d.sel = q.s_sel[1];
    // edge detector idles at the pin's reset level, so no false edge
    // follows reset while the host clock rests low
    scl_rise = q.s_scl[1] & ~q.scl;
    scl_fall = ~q.s_scl[1] & q.scl;
    // a host that only moves data while clock is low never looks
    // like a start or stop here
    start_c = q.s_scl[1] & q.scl & q.sda & ~q.s_sda[1];
    stop_c = q.s_scl[1] & q.scl & ~q.sda & q.s_sda[1];
    d.req = 1'b0;
    if (q.sel) begin
      // ----------------------------------------------------------------
      // four-wire slave
      // ----------------------------------------------------------------
      d.tw = serial_command_port_pkg::tw_idle;
      d.sda_oe = 1'b0;
      // a full buffer stalls sampling on writes; reads never push
      if (q.ss) begin
        d.cnt = '0;
        d.first = 1'b1;
        d.rd_dir = 1'b0;
        d.so = 1'b0;
      end else if (scl_rise && !(full && !q.rd_dir)) begin
        d.sh = shift_in(q.sh, q.sda);
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == serial_command_port_pkg::last_bit) begin
          // first byte: direction on top, address below it
          if (q.first) begin
            d.first = 1'b0;
            d.rd_dir = q.sh[serial_command_port_pkg::dir_pos - 1];
            d.cmd = {q.sh[5:0], q.sda};
            d.idx = '0;
            push = ~q.sh[serial_command_port_pkg::dir_pos - 1];
            push_w = '{is_cmd: 1'b1, data: {1'b0, q.sh[5:0], q.sda}};
            d.req = q.sh[serial_command_port_pkg::dir_pos - 1];
          end else if (!q.rd_dir) begin
            push = 1'b1;
            push_w = '{is_cmd: 1'b0, data: shift_in(q.sh, q.sda)};
          end else begin
            d.req = 1'b1;
          end
        end
      end else if (scl_fall && q.rd_dir) begin
        d.so = q.tx[7];
        d.tx = shift_out(q.tx);
      end
    end else begin
      // ----------------------------------------------------------------
      // two-wire slave
      // ----------------------------------------------------------------
      d.so = 1'b0;
      // stop wins over anything the sequencer was doing
      if (stop_c) begin
        d.tw = serial_command_port_pkg::tw_idle;
        d.sda_oe = 1'b0;
      end else if (start_c) begin
        // start and repeated start both restart address reception
        d.tw = serial_command_port_pkg::tw_addr;
        d.cnt = '0;
        d.sda_oe = 1'b0;
      end else begin
        case (q.tw)
          serial_command_port_pkg::tw_addr, serial_command_port_pkg::tw_wr:
          if (scl_rise && !full) begin
            d.sh = shift_in(q.sh, q.sda);
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == serial_command_port_pkg::last_bit) begin
              if (q.tw == serial_command_port_pkg::tw_addr) begin
                if (q.sh[6:2] == serial_command_port_pkg::addr_fixed &&
                    q.sh[1] == q.s_a1[1] && q.sh[0] == q.ss) begin
                  d.rd_dir = q.sda;
                  d.first = 1'b1;
                  d.idx = '0;
                  d.tw = serial_command_port_pkg::tw_wack;
                end else begin
                  d.tw = serial_command_port_pkg::tw_idle;
                end
              end else begin
                push = 1'b1;
                push_w = '{is_cmd: q.first, data: shift_in(q.sh, q.sda)};
                d.first = 1'b0;
                d.tw = serial_command_port_pkg::tw_wack;
              end
            end
          end
          // ninth clock: pull low on the fall, release on the next fall;
          // a read loads its first byte at that release
          serial_command_port_pkg::tw_wack: begin
            if (scl_fall && !q.sda_oe) begin
              d.sda_oe = 1'b1;
            end else if (scl_fall) begin
              d.sda_oe = 1'b0;
              d.cnt = '0;
              if (q.rd_dir) begin
                d.tw = serial_command_port_pkg::tw_rd;
                d.sda_oe = ~rd_data_i[7];
                d.tx = shift_out(rd_data_i);
                d.idx = q.idx + 8'h01;
              end else begin
                d.tw = serial_command_port_pkg::tw_wr;
              end
            end
            // read-back address is held by the command decoder
            d.req = q.rd_dir && scl_rise;
          end
          // a zero bit pulls the line, a one bit releases it
          serial_command_port_pkg::tw_rd:
          if (scl_fall) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == serial_command_port_pkg::last_bit) begin
              d.sda_oe = 1'b0;
              d.tw = serial_command_port_pkg::tw_rack;
            end else begin
              d.sda_oe = ~q.tx[7];
              d.tx = shift_out(q.tx);
            end
          end
          // host answer: low asks for more, high ends the read
          serial_command_port_pkg::tw_rack:
          if (scl_rise) begin
            d.req = ~q.sda;
            d.tw = q.sda ? serial_command_port_pkg::tw_idle
                         : serial_command_port_pkg::tw_wack;
            d.sda_oe = 1'b0;
          end
          // idle and any unused code wait for a start
          default: d.tw = serial_command_port_pkg::tw_idle;
        endcase
      end
    end
    // ----------------------------------------------------------------
    // four-wire read data load
    // ----------------------------------------------------------------
    // decoder data must stand while the request does; it is taken
    // at the edge that ends the request cycle
    if (q.req && q.sel) begin
      d.tx = rd_data_i;
      d.idx = q.idx + 8'h01;
    end
    // ----------------------------------------------------------------
    // two-entry receive buffer: stall holds the shifter
    // ----------------------------------------------------------------
    // two entries let one word wait while the next is shifted in;
    // a host that keeps clocking into a full buffer loses bits
    if (push) begin
      d.fifo[q.wp] = push_w;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.fcnt = q.fcnt + 2'(push) - 2'(pop);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      // select and its copy start deasserted so no frame opens
      q <= '{tw: serial_command_port_pkg::tw_idle,
             s_ss: 2'h3,
             ss: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pulls low, the pull-up gives the one
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  // registered, so the pin never glitches between host edges
  assign serial_data_out_pin_o = q.so;
  assign rx_valid_o = (q.fcnt != 2'h0);
  // oldest entry; stands until taken
  assign rx_word_o = q.fifo[q.rp];
  assign rd_req_o = q.req;
  assign rd_info_o = '{cmd: q.cmd, index: q.idx};
endmodule : serial_command_port

// ===== serial_command_port_pkg.sv
// package of constants and carrier structs for the serial command port
// assumes one 20 MHz clock; host pins are asynchronous to it
package serial_command_port_pkg;
  localparam logic [4:0] addr_fixed = 5'h0a;
  localparam int dir_pos = 7;
  localparam logic [2:0] last_bit = 3'h7;
  localparam int buf_depth = 2;

  typedef enum logic [2:0] {
    tw_idle = 3'b000,
    tw_addr = 3'b001,
    tw_wr = 3'b010,
    tw_wack = 3'b011,
    tw_rd = 3'b100,
    tw_rack = 3'b101
  } tw_state_e;

  // one byte leaving the port toward the command decoder
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } rx_word_s;

  // read request toward the command decoder
  typedef struct packed {
    logic [6:0] cmd;
    logic [7:0] index;
  } rd_req_s;
endpackage : serial_command_port_pkg

// ===== serial_command_port_chk.sv
// assertions on the serial command port's top-level ports
// assumes a bind from the bench top; one clock domain
`timescale 1ns/10ps
module serial_command_port_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic interface_select_pin_i,
  input wire logic scl_i,
  input wire logic slave_select_low_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic serial_data_out_pin_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire serial_command_port_pkg::rx_word_s rx_word_o,
  input wire logic rd_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------
  // properties
  // ---------------------------------
  AST_RD_GAP: assert property (rd_req_o |=> (!rd_req_o) [*8])
    else $error("read requests too close");
  AST_SEL_NO_REQ: assert property (slave_select_low_i [*8] |-> !rd_req_o)
    else $error("read request while deselected");
  AST_SEL_NO_PUSH: assert property (
    slave_select_low_i [*8] |-> !$rose(rx_valid_o))
    else $error("word pushed while deselected");
  AST_FOUR_WIRE_QUIET: assert property (
    interface_select_pin_i [*5] |-> !sda_oe_o)
    else $error("data pin driven in four-wire mode");
  AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o)
    else $error("valid dropped without ready");
  AST_RX_STABLE: assert property (
    rx_valid_o && !rx_ready_i |=> $stable(rx_word_o))
    else $error("word changed while stalled");
  // load after a request is exempt, only scl falls shift
  AST_SHIFT_EDGE: assert property (
    (scl_i && !rd_req_o) [*4] |=> $stable(serial_data_out_pin_o))
    else $error("read data moved while clock high");
  AST_SDA_LOW: assert property (sda_oe_o |-> !sda_o)
    else $error("open drain drives high");
  COV_READ: cover property (rd_req_o);
  COV_STALL: cover property ((rx_valid_o && !rx_ready_i) [*4]);
  COV_CMD: cover property (rx_valid_o && rx_ready_i && rx_word_o.is_cmd);
endmodule : serial_command_port_chk

// ===== host_model.sv
// four-wire host master model, the port's far side
// assumes the bench calls its tasks; link clock period 400 ns
`timescale 1ns/10ps
module host_model (
  output logic scl_o,
  output logic mosi_o,
  output logic ss_n_o,
  input wire logic miso_i
);
  initial begin
    scl_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end
  // clock idles low and stands still between frames
  task automatic xfer(input logic [7:0] b, input int n,
    output logic [7:0] r);
    r = 8'h00;
    ss_n_o = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = b[i];
      #200 scl_o = 1'b1;
      // late sample: port sees pins three clocks late
      #190 r[i] = miso_i;
      #10 scl_o = 1'b0;
    end
  endtask : xfer
  task automatic stop;
    #200 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #400;
  endtask : stop
endmodule : host_model

// ===== serial_command_port_tb_top.sv
// self-checking bench for the serial command port, four-wire side
// assumes host_model as far side and the package carrier structs
`timescale 1ns/10ps
module serial_command_port_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ifs = 1'b1;
  logic rx_ready_i = 1'b0;
  logic stall = 1'b0;
  logic scl, mosi, ss_n, serial_data_out_pin, rd_req_o, rx_valid_o, sda_oe;
  serial_command_port_pkg::rx_word_s rx_word_o;
  serial_command_port_pkg::rd_req_s rd_info_o;
  logic [8:0] q[$];
  logic [6:0] rcmd;
  logic [7:0] ridx, r;
  // decoder stand-in: data stands while the request does
  wire [7:0] rd_data_i = ridx ^ 8'h5a;
  int fail_count = 0;
  int checks_done = 0;
  always #25 mclk_i = ~mclk_i;
  serial_command_port dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .interface_select_pin_i(ifs), .scl_i(scl), .sda_i(mosi), .sda_o(),
    .sda_oe_o(sda_oe), .slave_select_low_i(ss_n),
    .address_strap_bit1_i(1'b0),
    .serial_data_out_pin_o(serial_data_out_pin), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_word_o(rx_word_o), .rd_req_o(rd_req_o),
    .rd_info_o(rd_info_o), .rd_data_i(rd_data_i));
  host_model host_u (.scl_o(scl), .mosi_o(mosi), .ss_n_o(ss_n),
    .miso_i(serial_data_out_pin));
  task automatic chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (e !== s) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // ---------------------------------
  // receiver and command decoder stand-ins
  // ---------------------------------
  always @(posedge mclk_i) rx_ready_i <= #1 !stall && 1'($urandom);
  // the port never forwards a read command word; skip one if seen
  always @(posedge mclk_i) begin
    if (!rst_i && rx_valid_o && rx_ready_i &&
        !(rx_word_o.is_cmd && rx_word_o.data[7])) begin
      if (q.size() == 0) chk("rx_extra", 16'h0, 16'h1);
      else chk("rx_word", 16'(q.pop_front()), 16'(rx_word_o));
    end
  end
  always @(posedge mclk_i) begin
    if (rd_req_o) begin
      chk("rd_info", 16'({rcmd, ridx}), 16'(rd_info_o));
      ridx <= ridx + 8'h01;
    end
    if (!rst_i && ifs) chk("sda_oe", 16'h0, 16'(sda_oe));
  end
  // ---------------------------------
  // stimulus
  // ---------------------------------
  task automatic frame(input logic [7:0] c, input int n, input bit keep);
    logic [7:0] p;
    rcmd = c[6:0];
    ridx = 8'h00;
    if (keep && !c[7]) q.push_back({1'b1, c});
    host_u.xfer(c, 8, r);
    for (int i = 0; i < n; i++) begin
      p = 8'($urandom);
      if (keep && !c[7] && (!stall || i == 0)) q.push_back({1'b0, p});
      host_u.xfer(p, 8, r);
      if (c[7]) chk("read_byte", 16'(8'(i) ^ 8'h5a), 16'(r));
    end
    host_u.stop();
  endtask : frame
  initial begin
    void'($urandom(32'h2d67));
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    frame({1'b0, 7'($urandom)}, 2, 1);
    frame({1'b1, 7'($urandom)}, 2, 1);
    host_u.xfer(8'h00, 4, r);
    host_u.stop();
    frame(8'h25, 1, 1);
    stall = 1'b1;
    frame(8'h11, 3, 1);
    repeat (20) @(posedge mclk_i);
    stall = 1'b0;
    @(posedge mclk_i) #1 ifs = 1'b0;
    repeat (5) @(posedge mclk_i);
    frame(8'h33, 2, 0);
    @(posedge mclk_i) #1 ifs = 1'b1;
    repeat (100) @(posedge mclk_i);
    chk("rx_left", 16'h0, 16'(q.size()));
    report_and_stop();
  end
  // about 60 us of traffic expected; generous margin
  initial begin
    #1_000_000;
    fail_count++;
    report_and_stop();
  end
endmodule : serial_command_port_tb_top
bind serial_command_port serial_command_port_chk chk_u (.mclk_i(mclk_i),
  .rst_i(rst_i), .interface_select_pin_i(interface_select_pin_i),
  .scl_i(scl_i), .slave_select_low_i(slave_select_low_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .serial_data_out_pin_o(serial_data_out_pin_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
  .rx_word_o(rx_word_o), .rd_req_o(rd_req_o));
